// ==== hdl/fpes_pkg.sv ====
// How it works
// RULE1: Suspend is the lone opcode B0h; bytes after it in the frame are ignored.
// RULE2: At chip-select release after suspend, the running operation is halted within latency.
// RULE3: When halted, buffer-one, buffer-two or erase suspend flag goes to 1.
// RULE4: Once suspension takes effect, the ready flag shows ready again.
// RULE5: Reads into a suspended 256 KB sector return undefined data.
// RULE6: Continuous read outputs undefined data only while inside a suspended sector.
// RULE7: A program aimed at the erase-suspended sector is refused.
// RULE8: During erase suspend a program elsewhere may run and itself be suspended.
// RULE9: Reset during sector erase suspend cancels it; whole sector becomes undefined.
// RULE10: Reset during page program or erase suspend cancels it; only that page corrupts.
// RULE11: Array reads and both buffer reads are allowed in every suspend state.
// RULE12: Host leaves the suspended program's buffer alone; the other buffer stays usable.
// RULE13: Buffer-to-memory program without erase only during erase suspend.
// RULE14: Memory program through buffer one without erase only during erase suspend.
// RULE15: No erasing programs, rewrites, read-modify-writes or erases while suspended.
// RULE16: No protection, lockdown or security-register changes while suspended.
// RULE17: Protection, lockdown and security register reads stay serviced while suspended.
// RULE18: Resume is D0h at chip-select release; flag clears and busy shows again.
// RULE19: With both suspended, resume continues the program first, then the erase.
// RULE20: Host enters no power-down and leaves none while anything is suspended.
// RULE21: Status, configuration, identification reads and resets accepted while suspended.
// RULE22: Commands not permitted in the current suspend state are ignored.
package fpes_pkg;

	// ----------------------------------------
	// Opcodes and sizes
	// ----------------------------------------
	localparam logic [7:0] OP_SUSPEND = 8'hB0;
	localparam logic [7:0] OP_RESUME  = 8'hD0;
	localparam int         SECTOR_W   = 6;
	localparam logic [7:0] UNDEF_BYTE = 8'hFF;
	localparam logic [2:0] BIT_LAST   = 3'h7;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CLK_PERIOD_NS       = 10;
	localparam int          SUSPEND_LATENCY_NS  = 20_000;
	localparam int          RESUME_LATENCY_NS   = 40_000;
	localparam int          CNT_W               = 12;
	localparam logic [11:0] SUSPEND_LATENCY_CYC = 12'(SUSPEND_LATENCY_NS / CLK_PERIOD_NS);
	localparam logic [11:0] RESUME_LATENCY_CYC  = 12'(RESUME_LATENCY_NS / CLK_PERIOD_NS);
	localparam logic [11:0] CNT_LAST            = 12'h0001;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [2:0] {
		CLS_READ,
		CLS_BUF1_USE,
		CLS_BUF2_USE,
		CLS_PROG_NOERASE,
		CLS_FORBIDDEN,
		CLS_OTHER
	} fpes_cmd_class_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SUSP_WAIT,
		ST_RES_WAIT
	} fpes_state_t;

	// ----------------------------------------
	// State records
	// ----------------------------------------
	typedef struct packed {
		logic       sck_s1;
		logic       sck_s2;
		logic       sck_d;
		logic       cs_s1;
		logic       cs_s2;
		logic       cs_d;
		logic       mosi_s1;
		logic       mosi_s2;
		logic       rst_s1;
		logic       rst_s2;
		logic [7:0] shift;
		logic [2:0] bitcnt;
		logic       first;
		logic       bvalid;
		logic [7:0] bdata;
		logic       bfirst;
		logic       fend;
	} fpes_front_t;

	typedef struct packed {
		fpes_state_t         state;
		logic [CNT_W-1:0]    cnt;
		logic                tgt_prog;
		logic                ps1;
		logic                ps2;
		logic                es;
		logic                es_page;
		logic [SECTOR_W-1:0] e_sector;
		logic [SECTOR_W-1:0] p_sector;
		logic [7:0]          opcode;
		logic                op_seen;
		logic                verdict_valid;
		logic                permit;
		logic [7:0]          rdata;
		logic                rundef;
		logic                wipe_sector;
		logic                wipe_page;
	} fpes_core_t;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam fpes_front_t FRONT_RESET = '{default: '0, cs_s1: 1'b1, cs_s2: 1'b1,
		cs_d: 1'b1, rst_s1: 1'b1, rst_s2: 1'b1, first: 1'b1};
	localparam fpes_core_t  CORE_RESET  = '{default: '0, state: ST_IDLE};

endpackage

// ==== hdl/fpes_spi_front.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpes_spi_front (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// Pins
	input  wire logic       spi_sck,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_mosi,
	input  wire logic       reset_pin_n,
	// Byte stream
	output logic            byte_valid,
	output logic [7:0]      byte_data,
	output logic            byte_first,
	output logic            frame_end,
	output logic            reset_pin_active
);
	import fpes_pkg::*;

	fpes_front_t r_r;
	fpes_front_t r_nxt;

	// ----------------------------------------
	// Synchronise pins and assemble bytes
	// ----------------------------------------
	always_comb begin
		r_nxt = r_r;
		r_nxt.sck_s1 = spi_sck;
		r_nxt.sck_s2 = r_r.sck_s1;
		r_nxt.sck_d = r_r.sck_s2;
		r_nxt.cs_s1 = spi_cs_n;
		r_nxt.cs_s2 = r_r.cs_s1;
		r_nxt.cs_d = r_r.cs_s2;
		r_nxt.mosi_s1 = spi_mosi;
		r_nxt.mosi_s2 = r_r.mosi_s1;
		r_nxt.rst_s1 = reset_pin_n;
		r_nxt.rst_s2 = r_r.rst_s1;
		r_nxt.bvalid = 1'b0;
		r_nxt.fend = r_r.cs_s2 && !r_r.cs_d;
		if (r_r.cs_s2) begin
			r_nxt.bitcnt = '0;
			r_nxt.first = 1'b1;
		end else if (r_r.sck_s2 && !r_r.sck_d) begin
			// Mode 0/3: data taken on rising clock
			r_nxt.shift = {r_r.shift[6:0], r_r.mosi_s2};
			r_nxt.bitcnt = r_r.bitcnt + 3'h1;
			if (r_r.bitcnt == BIT_LAST) begin
				r_nxt.bvalid = 1'b1;
				r_nxt.bdata = {r_r.shift[6:0], r_r.mosi_s2};
				r_nxt.bfirst = r_r.first;
				r_nxt.first = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r_r <= FRONT_RESET;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign byte_valid       = r_r.bvalid;
	assign byte_data        = r_r.bdata;
	assign byte_first       = r_r.bfirst;
	assign frame_end        = r_r.fend;
	assign reset_pin_active = !r_r.rst_s2;

endmodule
`default_nettype wire

// ==== hdl/fpes_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpes_top (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         arst_n,
	// Serial pins
	input  wire logic                         spi_sck,
	input  wire logic                         spi_cs_n,
	input  wire logic                         spi_mosi,
	input  wire logic                         reset_pin_n,
	// Software reset from command decoder
	input  wire logic                         soft_reset_req,
	// Program engine state
	input  wire logic                         core_prog_busy,
	input  wire logic                         core_prog_buf,
	input  wire logic [fpes_pkg::SECTOR_W-1:0] core_prog_sector,
	// Erase engine state
	input  wire logic                         core_erase_busy,
	input  wire logic                         core_erase_is_page,
	input  wire logic [fpes_pkg::SECTOR_W-1:0] core_erase_sector,
	// Command screening
	input  wire logic                         cmd_class_valid,
	input  wire fpes_pkg::fpes_cmd_class_t    cmd_class,
	input  wire logic                         cmd_is_program,
	input  wire logic [fpes_pkg::SECTOR_W-1:0] cmd_target_sector,
	// Array read path
	input  wire logic                         read_active,
	input  wire logic [fpes_pkg::SECTOR_W-1:0] read_sector,
	input  wire logic [7:0]                   read_byte_in,
	// Status flags
	output logic                              prog_suspend_buf_one_flag,
	output logic                              prog_suspend_buf_two_flag,
	output logic                              erase_suspend_flag,
	output logic                              ready_flag,
	// Engine control
	output logic                              prog_pause,
	output logic                              erase_pause,
	// Command verdict
	output logic                              cmd_verdict_valid,
	output logic                              cmd_permit,
	// Read data
	output logic [7:0]                        read_byte_out,
	output logic                              read_undefined,
	// Reset damage report
	output logic                              wipe_sector_pulse,
	output logic                              wipe_page_pulse
);
	import fpes_pkg::*;

	// ----------------------------------------
	// Front end
	// ----------------------------------------
	logic       byte_valid;
	logic [7:0] byte_data;
	logic       byte_first;
	logic       frame_end;
	logic       reset_pin_active;

	fpes_spi_front u_front (
		.sys_clk          (sys_clk),
		.arst_n           (arst_n),
		.spi_sck          (spi_sck),
		.spi_cs_n         (spi_cs_n),
		.spi_mosi         (spi_mosi),
		.reset_pin_n      (reset_pin_n),
		.byte_valid       (byte_valid),
		.byte_data        (byte_data),
		.byte_first       (byte_first),
		.frame_end        (frame_end),
		.reset_pin_active (reset_pin_active)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	fpes_core_t r_r;
	fpes_core_t r_nxt;
	logic       prog_susp;
	logic       any_susp;
	logic       allowed;
	logic       read_hit;
	logic       do_reset;

	// Summary of the current suspend state
	assign prog_susp = r_r.ps1 || r_r.ps2;
	assign any_susp  = prog_susp || r_r.es;
	assign do_reset  = reset_pin_active || soft_reset_req;

	// ----------------------------------------
	// Allowed-command table
	// ----------------------------------------
	always_comb begin
		allowed = 1'b1;
		if (any_susp) begin
			case (cmd_class)
				CLS_READ:         allowed = 1'b1;              // [RULE11] [RULE17] [RULE21]
				CLS_BUF1_USE:     allowed = !r_r.ps1;          // [RULE12]
				CLS_BUF2_USE:     allowed = !r_r.ps2;          // [RULE12]
				CLS_PROG_NOERASE: allowed = r_r.es && !prog_susp; // [RULE13] [RULE14]
				CLS_FORBIDDEN:    allowed = 1'b0;              // [RULE15] [RULE16] [RULE20]
				CLS_OTHER:        allowed = 1'b1;
				default:          allowed = 1'b0;
			endcase
		end
		// Programs into the erase-suspended sector abort
		if (r_r.es && cmd_is_program && cmd_target_sector == r_r.e_sector) begin
			allowed = 1'b0; // [RULE7]
		end
	end

	// ----------------------------------------
	// Suspended-sector read guard
	// ----------------------------------------
	always_comb begin
		read_hit = 1'b0;
		if (r_r.es && read_sector == r_r.e_sector) begin
			read_hit = 1'b1; // [RULE5]
		end
		if (prog_susp && read_sector == r_r.p_sector) begin
			read_hit = 1'b1; // [RULE5]
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		r_nxt = r_r;
		r_nxt.verdict_valid = 1'b0;
		r_nxt.wipe_sector = 1'b0;
		r_nxt.wipe_page = 1'b0;

		// Opcode is the first byte; later bytes only shift past
		if (byte_valid && byte_first) begin
			r_nxt.opcode = byte_data; // [RULE1]
			r_nxt.op_seen = 1'b1;
		end

		// Act on suspend or resume when chip select releases
		if (frame_end) begin
			r_nxt.op_seen = 1'b0;
			if (r_r.op_seen && r_r.state == ST_IDLE && r_r.opcode == OP_SUSPEND) begin
				if (core_prog_busy && !prog_susp) begin
					// Also covers a program started inside an erase suspend
					r_nxt.state = ST_SUSP_WAIT; // [RULE2] [RULE8]
					r_nxt.tgt_prog = 1'b1;
					r_nxt.cnt = SUSPEND_LATENCY_CYC;
				end else if (core_erase_busy && !r_r.es && !core_prog_busy) begin
					r_nxt.state = ST_SUSP_WAIT; // [RULE2]
					r_nxt.tgt_prog = 1'b0;
					r_nxt.cnt = SUSPEND_LATENCY_CYC;
				end
			end
			if (r_r.op_seen && r_r.state == ST_IDLE && r_r.opcode == OP_RESUME) begin
				if (prog_susp) begin
					r_nxt.state = ST_RES_WAIT; // [RULE18] [RULE19]
					r_nxt.tgt_prog = 1'b1;
					r_nxt.cnt = RESUME_LATENCY_CYC;
				end else if (r_r.es) begin
					r_nxt.state = ST_RES_WAIT; // [RULE18] [RULE19]
					r_nxt.tgt_prog = 1'b0;
					r_nxt.cnt = RESUME_LATENCY_CYC;
				end
			end
		end

		// Latency timers; a suspend during a resume wait is dropped above
		case (r_r.state)
			ST_IDLE: begin
				// Keep a timer just loaded above, otherwise clear leftovers
				if (r_nxt.state == ST_IDLE) begin
					r_nxt.cnt = '0;
				end
			end
			ST_SUSP_WAIT: begin
				r_nxt.cnt = r_r.cnt - CNT_LAST;
				if (r_r.cnt <= CNT_LAST) begin
					r_nxt.state = ST_IDLE;
					if (r_r.tgt_prog) begin
						r_nxt.ps1 = !core_prog_buf; // [RULE3] [RULE8]
						r_nxt.ps2 = core_prog_buf;  // [RULE3] [RULE8]
						r_nxt.p_sector = core_prog_sector;
					end else begin
						r_nxt.es = 1'b1; // [RULE3]
						r_nxt.es_page = core_erase_is_page;
						r_nxt.e_sector = core_erase_sector;
					end
				end
			end
			ST_RES_WAIT: begin
				r_nxt.cnt = r_r.cnt - CNT_LAST;
				if (r_r.cnt <= CNT_LAST) begin
					r_nxt.state = ST_IDLE;
					if (r_r.tgt_prog) begin
						r_nxt.ps1 = 1'b0; // [RULE18]
						r_nxt.ps2 = 1'b0; // [RULE18]
					end else begin
						r_nxt.es = 1'b0; // [RULE18]
					end
				end
			end
			default: begin
				r_nxt.state = ST_IDLE;
			end
		endcase

		// Verdict on every screened command; refused ones go nowhere
		if (cmd_class_valid) begin
			r_nxt.verdict_valid = 1'b1;
			r_nxt.permit = allowed; // [RULE22]
		end

		// Read data path, masked inside suspended sectors
		r_nxt.rundef = read_active && read_hit;               // [RULE6]
		r_nxt.rdata = read_hit ? UNDEF_BYTE : read_byte_in;   // [RULE5] [RULE6]

		// Reset aborts every suspension and reports what was damaged
		if (do_reset) begin
			r_nxt.wipe_sector = r_r.es && !r_r.es_page;         // [RULE9]
			r_nxt.wipe_page = (r_r.es && r_r.es_page) || prog_susp; // [RULE10]
			r_nxt.ps1 = 1'b0;
			r_nxt.ps2 = 1'b0;
			r_nxt.es = 1'b0; // [RULE9] [RULE10]
			r_nxt.es_page = 1'b0;
			r_nxt.state = ST_IDLE;
			r_nxt.cnt = '0;
			r_nxt.op_seen = 1'b0;
		end
	end

	// State register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r_r <= CORE_RESET;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Engines hold still from the start of the suspend wait to the end of resume
	assign prog_pause  = prog_susp || (r_r.state == ST_SUSP_WAIT && r_r.tgt_prog);  // [RULE2]
	assign erase_pause = r_r.es || (r_r.state == ST_SUSP_WAIT && !r_r.tgt_prog);    // [RULE2]

	// Ready once every engine still busy is paused and no timer runs
	assign ready_flag = !((core_prog_busy && !prog_pause) ||
		(core_erase_busy && !erase_pause) || r_r.state != ST_IDLE); // [RULE4] [RULE18]

	assign prog_suspend_buf_one_flag = r_r.ps1;
	assign prog_suspend_buf_two_flag = r_r.ps2;
	assign erase_suspend_flag        = r_r.es;
	assign cmd_verdict_valid         = r_r.verdict_valid;
	assign cmd_permit                = r_r.permit;
	assign read_byte_out             = r_r.rdata;
	assign read_undefined            = r_r.rundef;
	assign wipe_sector_pulse         = r_r.wipe_sector;
	assign wipe_page_pulse           = r_r.wipe_page;

endmodule
`default_nettype wire

// ==== verification/fpes_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpes_chk
	import fpes_pkg::*;
(
	// Clock, reset and stimulus
	input wire logic                sys_clk,
	input wire logic                arst_n,
	input wire logic                soft_reset_req,
	input wire logic                core_erase_is_page,
	input wire logic [SECTOR_W-1:0] core_erase_sector,
	input wire logic                cmd_class_valid,
	input wire fpes_cmd_class_t     cmd_class,
	input wire logic                cmd_is_program,
	input wire logic [SECTOR_W-1:0] cmd_target_sector,
	input wire logic                read_active,
	input wire logic [SECTOR_W-1:0] read_sector,
	input wire logic [7:0]          read_byte_in,
	// Responses
	input wire logic                prog_suspend_buf_one_flag,
	input wire logic                prog_suspend_buf_two_flag,
	input wire logic                erase_suspend_flag,
	input wire logic                ready_flag,
	input wire logic                prog_pause,
	input wire logic                erase_pause,
	input wire logic                cmd_verdict_valid,
	input wire logic                cmd_permit,
	input wire logic [7:0]          read_byte_out,
	input wire logic                read_undefined,
	input wire logic                wipe_sector_pulse
);
	localparam int LAT_LO = int'(SUSPEND_LATENCY_CYC) - 4;
	localparam int LAT_HI = int'(SUSPEND_LATENCY_CYC) + 4;
	// Short flag names
	wire logic ps1 = prog_suspend_buf_one_flag;
	wire logic ps2 = prog_suspend_buf_two_flag;
	wire logic es = erase_suspend_flag;
	logic [15:0] wait_r;
	logic [15:0] wait_nxt;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Cycles paused before the flag shows
	always_comb begin
		wait_nxt = 16'h0000;
		if ((prog_pause && !ps1 && !ps2) || (erase_pause && !es))
			wait_nxt = wait_r + 16'h0001;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			wait_r <= 16'h0000;
		else
			wait_r <= wait_nxt;
	end
	// Properties
	verdict_lat_a: assert property (cmd_class_valid |=> cmd_verdict_valid)
		else $error("verdict late");
	verdict_once_a: assert property (!cmd_class_valid |=> !cmd_verdict_valid)
		else $error("stray verdict");
	erase_hit_a: assert property (cmd_class_valid && cmd_is_program && es
		&& cmd_target_sector == core_erase_sector |=> !cmd_permit) else $error("program hit");
	forbid_cmd_a: assert property (cmd_class_valid && cmd_class == CLS_FORBIDDEN
		&& (ps1 || ps2 || es) |=> !cmd_permit) else $error("forbidden passed");
	read_cmd_a: assert property (cmd_class_valid && cmd_class == CLS_READ
		&& !cmd_is_program |=> cmd_permit) else $error("read refused");
	one_buf_a: assert property (!(ps1 && ps2))
		else $error("both buffer flags");
	flag_lat_a: assert property ($rose(ps1) || $rose(ps2) || $rose(es)
		|-> wait_r >= LAT_LO && wait_r <= LAT_HI) else $error("suspend latency");
	flag_ready_a: assert property ($rose(ps1) || $rose(ps2) || $rose(es) |-> ready_flag)
		else $error("not ready");
	erase_first_a: assert property (es && (ps1 || ps2) |=> es || !(ps1 || ps2))
		else $error("erase resumed first");
	read_undef_a: assert property (read_active && es && read_sector == core_erase_sector
		|=> read_undefined && read_byte_out == UNDEF_BYTE) else $error("read not masked");
	read_pass_a: assert property (read_active && !ps1 && !ps2 && !es
		|=> !read_undefined && read_byte_out == $past(read_byte_in)) else $error("read lost");
	reset_clear_a: assert property (soft_reset_req |=> !ps1 && !ps2 && !es)
		else $error("flags kept");
	wipe_sec_a: assert property (soft_reset_req && es && !core_erase_is_page
		|=> ##[0:1] wipe_sector_pulse) else $error("no sector wipe");
	// Scenario coverage
	cover property ($rose(es));
	cover property (es && ps2);
	cover property (read_undefined);
	cover property (wipe_sector_pulse);
endmodule
bind fpes_top fpes_chk u_fpes_chk (.sys_clk(sys_clk), .arst_n(arst_n),
	.soft_reset_req(soft_reset_req), .core_erase_is_page(core_erase_is_page),
	.core_erase_sector(core_erase_sector), .cmd_class_valid(cmd_class_valid),
	.cmd_class(cmd_class), .cmd_is_program(cmd_is_program),
	.cmd_target_sector(cmd_target_sector), .read_active(read_active),
	.read_sector(read_sector), .read_byte_in(read_byte_in),
	.prog_suspend_buf_one_flag(prog_suspend_buf_one_flag),
	.prog_suspend_buf_two_flag(prog_suspend_buf_two_flag),
	.erase_suspend_flag(erase_suspend_flag), .ready_flag(ready_flag),
	.prog_pause(prog_pause), .erase_pause(erase_pause),
	.cmd_verdict_valid(cmd_verdict_valid), .cmd_permit(cmd_permit),
	.read_byte_out(read_byte_out), .read_undefined(read_undefined),
	.wipe_sector_pulse(wipe_sector_pulse));
`default_nettype wire

// ==== verification/fpes_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpes_host_model (
	// Serial pins
	output var logic spi_sck,
	output var logic spi_cs_n,
	output var logic spi_mosi
);
	// Idle link: clock low, not selected
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b1;
	end
	// One byte, MSB first, sampled on rising clock
	task automatic shift_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			spi_mosi = b[i];
			#40;
			spi_sck = 1'b1;
			#40;
			spi_sck = 1'b0;
		end
	endtask
	// Opcode frame with a trailing byte; gap slows the host
	task automatic send(input logic [7:0] op, input logic [7:0] extra, input int gap);
		#3;
		spi_cs_n = 1'b0;
		#40;
		shift_byte(op);
		#(gap);
		shift_byte(extra);
		#40;
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#200;
	endtask
endmodule
`default_nettype wire

// ==== verification/fpes_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module fpes_tb_top;
	import fpes_pkg::*;
	// Bench state and design inputs
	int              seed = 32'h5e89_c683;
	int              failures = 0;
	int              checks = 0;
	logic [2:0]      st = 3'h0;
	logic            sys_clk = 1'b0;
	logic            arst_n = 1'b0;
	logic            reset_pin_n = 1'b1;
	logic            soft_reset_req = 1'b0;
	logic            pb = 1'b1;
	logic            bf = 1'b0;
	logic [5:0]      psec = 6'h05;
	logic            eb = 1'b0;
	logic            epg = 1'b0;
	logic [5:0]      esec = 6'h09;
	logic            cv = 1'b0;
	fpes_cmd_class_t cls = CLS_READ;
	logic            cprog = 1'b0;
	logic [5:0]      csec = 6'h00;
	logic            ra = 1'b0;
	logic [5:0]      rs = 6'h00;
	logic [7:0]      rb = 8'h00;
	// Link pins and design outputs
	wire logic       spi_sck, spi_cs_n, spi_mosi;
	logic            ps1, ps2, es, rdy, vv, permit, und, wsec, wpage;
	logic [7:0]      rbo;
	always #5 sys_clk = ~sys_clk;
	fpes_host_model u_fpes_host_model (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi));
	fpes_top u_fpes_top (.sys_clk(sys_clk), .arst_n(arst_n), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .reset_pin_n(reset_pin_n),
		.soft_reset_req(soft_reset_req), .core_prog_busy(pb), .core_prog_buf(bf),
		.core_prog_sector(psec), .core_erase_busy(eb), .core_erase_is_page(epg),
		.core_erase_sector(esec), .cmd_class_valid(cv), .cmd_class(cls),
		.cmd_is_program(cprog), .cmd_target_sector(csec), .read_active(ra),
		.read_sector(rs), .read_byte_in(rb), .prog_suspend_buf_one_flag(ps1),
		.prog_suspend_buf_two_flag(ps2), .erase_suspend_flag(es), .ready_flag(rdy),
		.prog_pause(), .erase_pause(), .cmd_verdict_valid(vv), .cmd_permit(permit),
		.read_byte_out(rbo), .read_undefined(und), .wipe_sector_pulse(wsec),
		.wipe_page_pulse(wpage));
	// Compare and count
	task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", w, exp, seen);
		end
	endtask
	// Expected verdict from the bench flag state
	function automatic logic exp_permit(int c, logic hit);
		if (hit)
			return 1'b0;
		if (st == 3'h0)
			return 1'b1;
		case (fpes_cmd_class_t'(c))
			CLS_BUF1_USE: return !st[2];
			CLS_BUF2_USE: return !st[1];
			CLS_PROG_NOERASE: return st == 3'h1;
			CLS_FORBIDDEN: return 1'b0;
			default: return 1'b1;
		endcase
	endfunction
	task automatic wait_flags(input logic [2:0] exp, input int lim);
		for (int i = 0; i < lim && {ps1, ps2, es} !== exp; i++)
			@(negedge sys_clk);
		check("flags", {5'h00, ps1, ps2, es}, {5'h00, exp});
	endtask
	// Suspend or resume frame, then flags and ready
	task automatic frame(input logic [7:0] op, input logic [2:0] nst, input int lim, input int gap);
		u_fpes_host_model.send(op, 8'h5a, gap);
		st = nst;
		wait_flags(nst, lim);
		check("ready", {7'h00, rdy}, {7'h00, op == OP_SUSPEND});
	endtask
	// Screen one command class
	task automatic screen(input int c, input logic [5:0] sec);
		logic pr;
		logic e;
		pr = (c == CLS_PROG_NOERASE) || (c == CLS_OTHER);
		e = exp_permit(c, pr && st[0] && sec == esec);
		@(posedge sys_clk);
		#1;
		cv = 1'b1;
		cls = fpes_cmd_class_t'(c);
		cprog = pr;
		csec = sec;
		@(posedge sys_clk);
		#1;
		cv = 1'b0;
		@(negedge sys_clk);
		check("verdict", {7'h00, vv}, 8'h01);
		check("permit", {7'h00, permit}, {7'h00, e});
	endtask
	task automatic table_run();
		for (int c = 0; c < 6; c++)
			screen(c, 6'($random(seed)));
		screen(CLS_OTHER, esec);
	endtask
	// Reads over suspended and free sectors
	task automatic sweep(input int n);
		logic [5:0] s;
		logic [7:0] b;
		logic       hit;
		for (int i = 0; i < n; i++) begin
			s = (i % 3 == 0) ? esec : (i % 3 == 1) ? psec : 6'($random(seed));
			b = 8'($random(seed));
			hit = (st[0] && s == esec) || (st[2:1] != 2'h0 && s == psec);
			@(posedge sys_clk);
			#1;
			ra = 1'b1;
			rs = s;
			rb = b;
			@(posedge sys_clk);
			@(negedge sys_clk);
			check("read data", rbo, hit ? UNDEF_BYTE : b);
			check("read undef", {7'h00, und}, {7'h00, hit});
		end
	endtask
	task automatic engines(input logic p, input logic e, input logic b, input logic pg,
		input logic [5:0] s);
		@(posedge sys_clk);
		#1;
		pb = p;
		eb = e;
		bf = b;
		epg = pg;
		psec = s;
	endtask
	task automatic wait_wipe(input logic page);
		int i;
		for (i = 0; i < 12; i++) begin
			@(negedge sys_clk);
			if ((page ? wpage : wsec) === 1'b1)
				break;
		end
		check("wipe", {7'h00, 1'(i < 12)}, 8'h01);
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		#1;
		arst_n = 1'b1;
		sweep(6);
		table_run();
		frame(OP_SUSPEND, 3'h4, 2200, 0);
		sweep(9);
		table_run();
		frame(OP_RESUME, 3'h0, 4200, 400);
		engines(1'b0, 1'b1, 1'b0, 1'b0, 6'h05);
		frame(OP_SUSPEND, 3'h1, 2200, 0);
		table_run();
		engines(1'b1, 1'b1, 1'b1, 1'b0, 6'h0c);
		frame(OP_SUSPEND, 3'h3, 2200, 0);
		sweep(9);
		table_run();
		frame(OP_RESUME, 3'h1, 4200, 0);
		frame(OP_RESUME, 3'h0, 4200, 0);
		engines(1'b0, 1'b1, 1'b1, 1'b0, 6'h0c);
		frame(OP_SUSPEND, 3'h1, 2200, 0);
		engines(1'b0, 1'b1, 1'b1, 1'b0, 6'h0c);
		soft_reset_req = 1'b1;
		st = 3'h0;
		wait_wipe(1'b0);
		@(posedge sys_clk);
		#1;
		soft_reset_req = 1'b0;
		wait_flags(3'h0, 4);
		engines(1'b0, 1'b1, 1'b1, 1'b1, 6'h0c);
		frame(OP_SUSPEND, 3'h1, 2200, 0);
		@(posedge sys_clk);
		#1;
		reset_pin_n = 1'b0;
		st = 3'h0;
		wait_wipe(1'b1);
		@(posedge sys_clk);
		#1;
		reset_pin_n = 1'b1;
		wait_flags(3'h0, 4);
		wrap_up();
	end
	// Watchdog
	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		wrap_up();
	end
endmodule
`default_nettype wire
